// file: hw/msg_sb_consts.svh
// Constants for the sideband message interface: field positions, codes and timing counts
`ifndef MSG_SB_CONSTS_SVH
`define MSG_SB_CONSTS_SVH

// Transmit kind codes
`define TX_KIND_LTR        3'h0
`define TX_KIND_OBFF       3'h1
`define TX_KIND_SSPL       3'h2
`define TX_KIND_PME        3'h3

// LTR payload fields
`define LTR_SNOOP_REQ      31
`define LTR_SNOOP_SCALE    28:26
`define LTR_SNOOP_VALUE    25:16
`define LTR_NOSNOOP_REQ    15
`define LTR_NOSNOOP_SCALE  12:10
`define LTR_NOSNOOP_VALUE  9:0

// OBFF, slot power and PME payload fields
`define OBFF_CODE          3:0
`define SSPL_FIELD         9:0
`define PME_PF             1:0
`define PME_VF             9:4

// Cycles the device spends sending one message before acknowledging
`define TX_BUSY_CYCLES     4'h3

// Received-message table depth (one entry per 5-bit kind)
`define RX_KINDS           32

`endif

// file: hw/msg_sb_pkg.sv
// Types shared by both ends of the sideband message interface
package msg_sb_pkg;
   typedef logic [4:0]  rx_kind_t;
   typedef logic [2:0]  tx_kind_t;
   typedef logic [31:0] tx_payload_t;
   typedef logic [7:0]  rx_param_t;
endpackage

// file: hw/msg_sb_if.sv
// Interface joining the device end and the user end of the message sideband
`timescale 1ns/1ps
`default_nettype none
interface msg_sb_if;
   logic                   msg_rx_strobe;
   msg_sb_pkg::rx_param_t  msg_rx_param;
   msg_sb_pkg::rx_kind_t   msg_rx_kind;
   logic                   msg_tx_req;
   msg_sb_pkg::tx_kind_t   msg_tx_kind;
   msg_sb_pkg::tx_payload_t msg_tx_payload;
   logic                   msg_tx_ack;

   modport device (
      output msg_rx_strobe, msg_rx_param, msg_rx_kind, msg_tx_ack,
      input  msg_tx_req, msg_tx_kind, msg_tx_payload
   );
   modport user (
      input  msg_rx_strobe, msg_rx_param, msg_rx_kind, msg_tx_ack,
      output msg_tx_req, msg_tx_kind, msg_tx_payload
   );
endinterface
`default_nettype wire

// file: hw/msg_sb_device.sv
// Device end of the message sideband: received-message reporting and message transmit
//
// Operation
// - Strobe high one or more cycles per message
// - Parameter bytes valid only while strobe high
// - At least one idle cycle between messages
// - Kind code shown while strobe high
// - Receive path only when enabled at build
// - User holds request stable until acknowledge
// - Kind codes: LTR, OBFF, SSPL, PME
// - LTR payload field layout
// - OBFF code in payload bits 3:0
// - Slot power scale and value bits 9:0
// - PME function flags in bits 1:0, 9:4
// - Acknowledge pulses one cycle on completion
`include "msg_sb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module msg_sb_device #(
   parameter bit        RX_ENABLE = 1'b1,
   parameter bit [127:0] RX_LEN_TABLE = {32{4'h1}}
) (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // Sideband toward the user logic
   msg_sb_if.device                     sb,
   // Decoded messages from the link side
   input  wire logic                    link_msg_valid,
   output logic                         link_msg_ready,
   input  wire msg_sb_pkg::rx_kind_t    link_msg_kind,
   input  wire logic [63:0]             link_msg_params,
   // Encoded message toward the link side
   output logic                         link_tx_valid,
   output logic [2:0]                   link_tx_kind,
   output logic [31:0]                  link_tx_fields
);

   // ----------------------------------------------------------------
   // Receive reporting
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {RX_IDLE, RX_SEND, RX_GAP} rx_state_t;

   rx_state_t            rx_state_reg;
   rx_state_t            rx_state_next;
   logic [3:0]           rx_left_reg;
   logic [3:0]           rx_left_next;
   logic [63:0]          rx_shift_reg;
   logic [63:0]          rx_shift_next;
   logic                 rx_strobe_reg;
   logic                 rx_strobe_next;
   msg_sb_pkg::rx_kind_t rx_kind_reg;
   msg_sb_pkg::rx_kind_t rx_kind_next;
   logic [7:0]           rx_param_reg;
   logic [7:0]           rx_param_next;
   logic                 ready_reg;

   wire  [3:0] rx_len_raw = RX_LEN_TABLE[{2'h0, link_msg_kind} * 7'h4 +: 4];
   wire  [3:0] rx_len     = (rx_len_raw == 4'h0) ? 4'h1 : rx_len_raw;
   wire        rx_accept  = RX_ENABLE && (rx_state_reg == RX_IDLE) && link_msg_valid;

   always_comb begin
      rx_state_next  = rx_state_reg;
      rx_left_next   = rx_left_reg;
      rx_shift_next  = rx_shift_reg;
      rx_strobe_next = 1'b0;
      rx_kind_next   = 5'h00;
      rx_param_next  = 8'h00;
      unique case (rx_state_reg)
         RX_IDLE: begin
            if (rx_accept) begin
               rx_strobe_next = 1'b1;
               rx_kind_next   = link_msg_kind;
               rx_param_next  = link_msg_params[7:0];
               rx_shift_next  = {8'h00, link_msg_params[63:8]};
               rx_left_next   = rx_len - 4'h1;
               rx_state_next  = (rx_len == 4'h1) ? RX_GAP : RX_SEND;
            end
         end
         RX_SEND: begin
            rx_strobe_next = 1'b1;
            rx_kind_next   = rx_kind_reg;
            rx_param_next  = rx_shift_reg[7:0];
            rx_shift_next  = {8'h00, rx_shift_reg[63:8]};
            rx_left_next   = rx_left_reg - 4'h1;
            if (rx_left_reg == 4'h1) begin
               rx_state_next = RX_GAP;
            end
         end
         RX_GAP: begin
            // Strobe goes low in the cycle after this one, separating messages
            rx_state_next = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_reg  <= RX_IDLE;
         rx_left_reg   <= 4'h0;
         rx_shift_reg  <= 64'h0;
         rx_strobe_reg <= 1'b0;
         rx_kind_reg   <= 5'h00;
         rx_param_reg  <= 8'h00;
         ready_reg     <= 1'b0;
      end else begin
         rx_state_reg  <= rx_state_next;
         rx_left_reg   <= rx_left_next;
         rx_shift_reg  <= rx_shift_next;
         rx_strobe_reg <= rx_strobe_next;
         rx_kind_reg   <= rx_kind_next;
         rx_param_reg  <= rx_param_next;
         ready_reg     <= rx_accept;
      end
   end

   // Kind register clears with the strobe so no stale code leaks outside a message
   assign sb.msg_rx_strobe = rx_strobe_reg;
   assign sb.msg_rx_kind   = rx_kind_reg;
   assign sb.msg_rx_param  = rx_param_reg;
   assign link_msg_ready   = ready_reg;

   // ----------------------------------------------------------------
   // Transmit
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {TX_IDLE, TX_BUSY, TX_DONE} tx_state_t;

   tx_state_t   tx_state_reg;
   tx_state_t   tx_state_next;
   logic [3:0]  tx_cnt_reg;
   logic [3:0]  tx_cnt_next;
   logic        ack_reg;
   logic        ltx_valid_reg;
   logic [2:0]  ltx_kind_reg;
   logic [31:0] ltx_fields_reg;
   logic [31:0] fields_sel;

   wire [31:0] pay      = sb.msg_tx_payload;
   // Reserved kinds are completed without sending, so the user is never hung
   wire        kind_ok  = (sb.msg_tx_kind[2] == 1'b0);
   wire        tx_start = (tx_state_reg == TX_IDLE) && sb.msg_tx_req;

   always_comb begin
      fields_sel = 32'h0;
      unique case (sb.msg_tx_kind)
         `TX_KIND_LTR: begin
            fields_sel[`LTR_SNOOP_REQ]     = pay[`LTR_SNOOP_REQ];
            fields_sel[`LTR_SNOOP_SCALE]   = pay[`LTR_SNOOP_SCALE];
            fields_sel[`LTR_SNOOP_VALUE]   = pay[`LTR_SNOOP_VALUE];
            fields_sel[`LTR_NOSNOOP_REQ]   = pay[`LTR_NOSNOOP_REQ];
            fields_sel[`LTR_NOSNOOP_SCALE] = pay[`LTR_NOSNOOP_SCALE];
            fields_sel[`LTR_NOSNOOP_VALUE] = pay[`LTR_NOSNOOP_VALUE];
         end
         `TX_KIND_OBFF: fields_sel[`OBFF_CODE]  = pay[`OBFF_CODE];
         `TX_KIND_SSPL: fields_sel[`SSPL_FIELD] = pay[`SSPL_FIELD];
         `TX_KIND_PME: begin
            fields_sel[`PME_PF] = pay[`PME_PF];
            fields_sel[`PME_VF] = pay[`PME_VF];
         end
         default: fields_sel = 32'h0;
      endcase
   end

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_cnt_next   = tx_cnt_reg;
      unique case (tx_state_reg)
         TX_IDLE: begin
            if (tx_start) begin
               tx_cnt_next   = `TX_BUSY_CYCLES;
               tx_state_next = TX_BUSY;
            end
         end
         TX_BUSY: begin
            tx_cnt_next = tx_cnt_reg - 4'h1;
            if (tx_cnt_reg == 4'h1) begin
               tx_state_next = TX_DONE;
            end
         end
         TX_DONE: begin
            // One wait cycle lets the user drop the request after the pulse
            tx_state_next = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_reg   <= TX_IDLE;
         tx_cnt_reg     <= 4'h0;
         ack_reg        <= 1'b0;
         ltx_valid_reg  <= 1'b0;
         ltx_kind_reg   <= 3'h0;
         ltx_fields_reg <= 32'h0;
      end else begin
         tx_state_reg  <= tx_state_next;
         tx_cnt_reg    <= tx_cnt_next;
         ack_reg       <= (tx_state_reg == TX_BUSY) && (tx_cnt_reg == 4'h1);
         ltx_valid_reg <= tx_start && kind_ok;
         if (tx_start) begin
            ltx_kind_reg   <= sb.msg_tx_kind;
            ltx_fields_reg <= fields_sel;
         end
      end
   end

   assign sb.msg_tx_ack  = ack_reg;
   assign link_tx_valid  = ltx_valid_reg;
   assign link_tx_kind   = ltx_kind_reg;
   assign link_tx_fields = ltx_fields_reg;

endmodule
`default_nettype wire

// file: hw/msg_sb_user.sv
// User end of the message sideband: issues transmit requests and captures received messages
`include "msg_sb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module msg_sb_user (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // Sideband toward the device
   msg_sb_if.user                        sb,
   // Send command from the application
   input  wire logic                     send_start,
   input  wire msg_sb_pkg::tx_kind_t     send_kind,
   input  wire msg_sb_pkg::tx_payload_t  send_payload,
   output logic                          send_busy,
   output logic                          send_done,
   // Received message report to the application
   output logic                          rx_done,
   output msg_sb_pkg::rx_kind_t          rx_kind,
   output logic [63:0]                   rx_params,
   output logic [3:0]                    rx_count
);

   // ----------------------------------------------------------------
   // Transmit request holding
   // ----------------------------------------------------------------
   logic                    req_reg;
   msg_sb_pkg::tx_kind_t    kind_reg;
   msg_sb_pkg::tx_payload_t pay_reg;
   logic                    done_reg;

   // Reserved kinds are refused here so they never reach the device
   wire accept = send_start && !req_reg && (send_kind[2] == 1'b0);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         req_reg  <= 1'b0;
         kind_reg <= 3'h0;
         pay_reg  <= 32'h0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= req_reg && sb.msg_tx_ack;
         if (req_reg && sb.msg_tx_ack) begin
            req_reg <= 1'b0;
         end else if (accept) begin
            req_reg  <= 1'b1;
            kind_reg <= send_kind;
            pay_reg  <= send_payload;
         end
      end
   end

   assign sb.msg_tx_req     = req_reg;
   assign sb.msg_tx_kind    = kind_reg;
   assign sb.msg_tx_payload = pay_reg;
   assign send_busy         = req_reg;
   assign send_done         = done_reg;

   // ----------------------------------------------------------------
   // Receive capture
   // ----------------------------------------------------------------
   logic                 strobe_d_reg;
   logic                 rx_done_reg;
   msg_sb_pkg::rx_kind_t rx_kind_reg;
   logic [63:0]          acc_reg;
   logic [63:0]          params_reg;
   logic [3:0]           cnt_reg;
   logic [3:0]           count_reg;

   wire first = sb.msg_rx_strobe && !strobe_d_reg;
   wire last  = !sb.msg_rx_strobe && strobe_d_reg;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         strobe_d_reg <= 1'b0;
         rx_done_reg  <= 1'b0;
         rx_kind_reg  <= 5'h00;
         acc_reg      <= 64'h0;
         params_reg   <= 64'h0;
         cnt_reg      <= 4'h0;
         count_reg    <= 4'h0;
      end else begin
         strobe_d_reg <= sb.msg_rx_strobe;
         rx_done_reg  <= last;
         if (first) begin
            rx_kind_reg <= sb.msg_rx_kind;
            acc_reg     <= {56'h0, sb.msg_rx_param};
            cnt_reg     <= 4'h1;
         end else if (sb.msg_rx_strobe) begin
            // Bytes only count while the strobe is high
            acc_reg <= acc_reg | ({56'h0, sb.msg_rx_param} << {cnt_reg[2:0], 3'h0});
            cnt_reg <= cnt_reg + 4'h1;
         end
         if (last) begin
            params_reg <= acc_reg;
            count_reg  <= cnt_reg;
         end
      end
   end

   assign rx_done   = rx_done_reg;
   assign rx_kind   = rx_kind_reg;
   assign rx_params = params_reg;
   assign rx_count  = count_reg;

endmodule
`default_nettype wire

// file: tb/msg_sb_properties.sv
// Concurrent checks on the sideband joining the device and user ends
`timescale 1ns/1ps
`default_nettype none
module msg_sb_properties #(
   parameter bit [127:0] RX_LEN_TABLE = {32{4'h1}}
) (
   // Clock and reset
   input wire logic                    clk_sys,
   input wire logic                    rst_n,
   // Receive direction
   input wire logic                    msg_rx_strobe,
   input wire msg_sb_pkg::rx_param_t   msg_rx_param,
   input wire msg_sb_pkg::rx_kind_t    msg_rx_kind,
   // Transmit direction
   input wire logic                    msg_tx_req,
   input wire msg_sb_pkg::tx_kind_t    msg_tx_kind,
   input wire msg_sb_pkg::tx_payload_t msg_tx_payload,
   input wire logic                    msg_tx_ack
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Strobe run length, held against the table entry of the kind shown
   logic [3:0] run_cnt_reg;
   wire  [3:0] kind_len_raw = RX_LEN_TABLE[{2'h0, msg_rx_kind} * 7'h4 +: 4];
   wire  [3:0] kind_len     = (kind_len_raw == 4'h0) ? 4'h1 : kind_len_raw;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_cnt_reg <= 4'h0;
      end else begin
         run_cnt_reg <= msg_rx_strobe ? run_cnt_reg + 4'h1 : 4'h0;
      end
   end

   // ----------------------------------------
   // Receive reporting
   // ----------------------------------------
   // Longest table entry in the bench is 8 cycles
   chk_strobe_bounded: assert property ($rose(msg_rx_strobe) |-> ##[1:9] !msg_rx_strobe)
      else $error("receive strobe held too long");
   chk_param_idle_zero: assert property (!msg_rx_strobe |-> msg_rx_param == 8'h00)
      else $error("parameter byte driven outside strobe");
   // Two messages run together would outlast the table entry of the first
   chk_rx_gap_kept: assert property (msg_rx_strobe |-> run_cnt_reg < kind_len)
      else $error("receive messages merged without gap");
   chk_strobe_len: assert property ($fell(msg_rx_strobe) |-> run_cnt_reg == $past(kind_len))
      else $error("receive strobe length differs from its kind");
   chk_kind_idle_zero: assert property (!msg_rx_strobe |-> msg_rx_kind == 5'h00)
      else $error("kind driven outside strobe");
   chk_kind_held: assert property (msg_rx_strobe && $past(msg_rx_strobe) |-> $stable(msg_rx_kind))
      else $error("kind changed within one message");

   // ----------------------------------------
   // Transmit handshake
   // ----------------------------------------
   chk_tx_kind_legal: assert property (msg_tx_req |-> msg_tx_kind <= 3'h3)
      else $error("reserved transmit kind requested");
   chk_req_held: assert property (msg_tx_req && !msg_tx_ack |=> msg_tx_req && $stable(msg_tx_kind)
      && $stable(msg_tx_payload))
      else $error("request not held until acknowledge");
   chk_ack_answers_req: assert property (msg_tx_ack |-> msg_tx_req && $past(msg_tx_req, 3))
      else $error("acknowledge without pending request");
   chk_ack_single: assert property (msg_tx_ack |=> !msg_tx_ack && !msg_tx_req)
      else $error("acknowledge longer than one cycle or request kept");
   chk_ack_in_time: assert property ($rose(msg_tx_req) |-> ##[3:8] msg_tx_ack)
      else $error("acknowledge missing");

   cover property ($rose(msg_tx_ack));
   cover property (msg_rx_strobe [*3]);
   cover property ($fell(msg_rx_strobe) ##1 msg_rx_strobe);
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench joining the device and user ends of the message sideband
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Kind 5 spans 3 cycles and kind 9 all 8 bytes, to reach multi-cycle reports
   localparam bit [127:0] LEN_TABLE = {{22{4'h1}}, 4'h8, {3{4'h1}}, 4'h3, {5{4'h1}}};
   typedef struct {msg_sb_pkg::rx_kind_t kind; logic [63:0] params; logic [3:0] count;} rx_note_t;
   typedef struct {msg_sb_pkg::tx_kind_t kind; msg_sb_pkg::tx_payload_t fields;} tx_note_t;
   logic                    clk_sys, rst_n, link_msg_valid, link_msg_ready, off_ready;
   logic                    off_req, off_tx_valid;
   logic                    off_seen = 1'b0;
   logic                    link_tx_valid, send_start, send_busy, send_done, rx_done;
   logic [2:0]              link_tx_kind;
   logic [31:0]             link_tx_fields, lfsr;
   logic [63:0]             link_msg_params, rx_params;
   logic [3:0]              rx_count;
   msg_sb_pkg::rx_kind_t    link_msg_kind, rx_kind;
   msg_sb_pkg::tx_kind_t    send_kind;
   msg_sb_pkg::tx_payload_t send_payload;
   int                      miscompares, checks;
   rx_note_t                rx_q[$], rx_exp;
   tx_note_t                tx_q[$], tx_exp;
   msg_sb_if sb();
   msg_sb_if sb_off();

   // ----------------------------------------
   // Design and checker
   // ----------------------------------------
   msg_sb_device #(.RX_ENABLE(1'b1), .RX_LEN_TABLE(LEN_TABLE)) msg_sb_device_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .sb(sb), .link_msg_valid(link_msg_valid),
      .link_msg_ready(link_msg_ready), .link_msg_kind(link_msg_kind),
      .link_msg_params(link_msg_params), .link_tx_valid(link_tx_valid),
      .link_tx_kind(link_tx_kind), .link_tx_fields(link_tx_fields));
   // Receive path built out: sees the same link traffic but must stay silent
   msg_sb_device #(.RX_ENABLE(1'b0), .RX_LEN_TABLE(LEN_TABLE)) msg_sb_device_off_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .sb(sb_off), .link_msg_valid(link_msg_valid),
      .link_msg_ready(off_ready), .link_msg_kind(link_msg_kind),
      .link_msg_params(link_msg_params), .link_tx_valid(off_tx_valid), .link_tx_kind(),
      .link_tx_fields());
   // Reserved kind straight into the device: acknowledged, never sent
   assign sb_off.msg_tx_req = off_req;
   assign sb_off.msg_tx_kind = 3'h5;
   assign sb_off.msg_tx_payload = 32'h0;
   msg_sb_user msg_sb_user_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .sb(sb), .send_start(send_start),
      .send_kind(send_kind), .send_payload(send_payload), .send_busy(send_busy),
      .send_done(send_done), .rx_done(rx_done), .rx_kind(rx_kind), .rx_params(rx_params),
      .rx_count(rx_count));
   msg_sb_properties #(.RX_LEN_TABLE(LEN_TABLE)) msg_sb_properties_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .msg_rx_strobe(sb.msg_rx_strobe),
      .msg_rx_param(sb.msg_rx_param), .msg_rx_kind(sb.msg_rx_kind), .msg_tx_req(sb.msg_tx_req),
      .msg_tx_kind(sb.msg_tx_kind), .msg_tx_payload(sb.msg_tx_payload),
      .msg_tx_ack(sb.msg_tx_ack));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [31:0] field_mask(input msg_sb_pkg::tx_kind_t k);
      case (k)
         3'h0: return 32'h9fff9fff;
         3'h1: return 32'h0000000f;
         3'h2: return 32'h000003ff;
         default: return 32'h000003f3;
      endcase
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Sampled at the falling edge so design updates of the rising edge have landed
   task automatic wait_hi(input bit want_ready);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while ((want_ready ? link_msg_ready : send_done) !== 1'b1 && n < 40);
      if (n >= 40) begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic rx_send(input msg_sb_pkg::rx_kind_t k, input logic [63:0] p);
      rx_note_t note;
      note.kind = k;
      note.count = LEN_TABLE[4*k +: 4];
      note.params = p & ({64{1'b1}} >> (64 - 8 * note.count));
      rx_q.push_back(note);
      @(posedge clk_sys);
      link_msg_valid  <= 1'b1;
      link_msg_kind   <= k;
      link_msg_params <= p;
      wait_hi(1'b1);
   endtask
   task automatic tx_send(input msg_sb_pkg::tx_kind_t k, input logic [31:0] p);
      tx_note_t note;
      note.kind = k;
      note.fields = p & field_mask(k);
      tx_q.push_back(note);
      @(posedge clk_sys);
      send_start   <= 1'b1;
      send_kind    <= k;
      send_payload <= p;
      @(posedge clk_sys);
      send_start <= 1'b0;
      wait_hi(1'b0);
   endtask

   // ----------------------------------------
   // Result watchers
   // ----------------------------------------
   always @(negedge clk_sys) begin
      if (rst_n && rx_done === 1'b1) begin
         rx_exp = rx_q.pop_front();
         check(rx_kind, rx_exp.kind);
         check(rx_count, rx_exp.count);
         check(rx_params & ({64{1'b1}} >> (64 - 8 * rx_exp.count)), rx_exp.params);
      end
      if (rst_n && link_tx_valid === 1'b1) begin
         tx_exp = tx_q.pop_front();
         check(link_tx_kind, tx_exp.kind);
         check(link_tx_fields, tx_exp.fields);
      end
      if (rst_n)
         off_seen <= off_seen | (sb_off.msg_rx_strobe !== 1'b0) | (off_ready !== 1'b0)
                     | (off_tx_valid !== 1'b0);
   end

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      {rst_n, link_msg_valid, send_start, off_req} = 4'h0;
      link_msg_kind = 5'h00;
      link_msg_params = 64'h0;
      send_kind = 3'h0;
      send_payload = 32'h0;
      lfsr = 32'h58712802;
      miscompares = 0;
      checks = 0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Both directions at once, each back to back
      fork
         begin
            for (int k = 0; k < 32; k++)
               rx_send(5'(k), {rnd(), rnd()});
            @(posedge clk_sys);
            link_msg_valid <= 1'b0;
            $display("Receive test done");
         end
         begin
            for (int r = 0; r < 3; r++)
               for (int k = 0; k < 4; k++)
                  tx_send(3'(k), (r == 0) ? 32'hffffffff : rnd());
            $display("Transmit test done");
         end
      join
      // Reserved kinds: the user end refuses them, the device acks without sending
      @(posedge clk_sys);
      send_start <= 1'b1;
      send_kind  <= 3'h4;
      off_req    <= 1'b1;
      @(posedge clk_sys);
      send_start <= 1'b0;
      @(negedge clk_sys);
      check(64'(send_busy), 64'h0);
      for (int n = 0; n < 8 && sb_off.msg_tx_ack !== 1'b1; n++)
         @(negedge clk_sys);
      check(64'(sb_off.msg_tx_ack), 64'h1);
      @(posedge clk_sys);
      off_req <= 1'b0;
      $display("Reserved kind test done");
      repeat (20) @(negedge clk_sys);
      check(64'(rx_q.size()), 64'h0);
      check(64'(tx_q.size()), 64'h0);
      check(64'(off_seen), 64'h0);
      $display("Disabled receive test done");
      conclude();
   end
endmodule
`default_nettype wire
